// File: hdl/amp_chan_diag.sv
`timescale 1ns/10ps
`include "amp_defines.svh"
module amp_chan_diag import amp_pkg::*; #(
  parameter int          IDX       = 0,
  parameter int unsigned ACQ_CYC   =
    `AMP_ACQ_MS * `AMP_CLK_MHZ * `AMP_KHZ_PER_MHZ,
  parameter int unsigned RECHK_CYC =
    `AMP_RECHK_MS * `AMP_CLK_MHZ * `AMP_KHZ_PER_MHZ
) (
  input  wire logic                mclk,
  input  wire logic                rst_n,
  input  wire logic [`AMP_F_W-1:0] flt_pins,
  amp_diag_if.chan                 dif
);

  localparam logic [`AMP_CNT_W-1:0] ACQ_END = `AMP_CNT_W'(ACQ_CYC - 1);
  localparam logic [`AMP_CNT_W-1:0] RCK_END = `AMP_CNT_W'(RECHK_CYC - 1);

  logic [`AMP_F_W-1:0]   s1_ff;
  logic [`AMP_F_W-1:0]   s2_ff;
  amp_cyc_st_t           st_ff;
  logic [`AMP_CNT_W-1:0] cnt_ff;
  logic [`AMP_F_W-1:0]   acc_ff;
  amp_flt_t              res_ff;
  logic                  type_ff;
  logic                  armed_ff;
  logic                  done_ff;
  logic                  ofs_q_ff;
  logic                  ofs_acc_ff;
  logic                  ofs_res_ff;
  logic                  scp;
  logic                  end_evt;
  logic                  bit2;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= '0;
      s2_ff <= '0;
    end else begin
      s1_ff <= flt_pins;
      s2_ff <= s1_ff;
    end
  end

  assign scp = s2_ff[`AMP_F_SCP];
  assign end_evt = dif.diag_en && (st_ff == CY_PERM || st_ff == CY_TON)
                   && cnt_ff == ACQ_END;

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff  <= CY_IDLE;
      cnt_ff <= '0;
    end else if (!dif.diag_en) begin
      st_ff  <= CY_IDLE;
      cnt_ff <= '0;
    end else begin
      unique case (st_ff)
        CY_IDLE: begin
          cnt_ff <= '0;
          // A read re-arms and requests a turn-on cycle in the same cycle.
          if ((armed_ff || dif.rearm) && dif.ton_start) st_ff <= CY_TON;
          // [R24] overload starts recheck
          else if (armed_ff && dif.amp_on && scp) st_ff <= CY_RECHK;
        end
        CY_RECHK: begin
          // [R24] recheck after delay
          if (cnt_ff == RCK_END) begin
            cnt_ff <= '0;
            st_ff  <= scp ? CY_PERM : CY_IDLE;
          end else begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
        CY_PERM, CY_TON: begin
          if (cnt_ff == ACQ_END) begin
            cnt_ff <= '0;
            st_ff  <= CY_IDLE;
          end else begin
            cnt_ff <= cnt_ff + 1'b1;
          end
        end
      endcase
    end
  end

  // [R17] persistence over period
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) acc_ff <= '0;
    else if (st_ff == CY_IDLE || st_ff == CY_RECHK) acc_ff <= s2_ff;
    else acc_ff <= acc_ff & s2_ff;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      res_ff  <= '0;
      type_ff <= 1'b0;
    end else if (end_evt) begin
      // [R19] double fault priority
      // [R20] no open load permanently
      res_ff  <= amp_prio(st_ff == CY_TON, acc_ff[`AMP_F_GND_SO],
                          acc_ff[`AMP_F_GND_SK], acc_ff[`AMP_F_VS],
                          acc_ff[`AMP_F_LOAD], acc_ff[`AMP_F_OPEN]);
      type_ff <= (st_ff == CY_PERM);
    end
  end

  // [R16] read re-arms cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) armed_ff <= 1'b1;
    else if (dif.rearm) armed_ff <= 1'b1;
    else if (end_evt) armed_ff <= 1'b0;
  end

  // [R11] terminated flag
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) done_ff <= 1'b0;
    else if (end_evt) done_ff <= 1'b1;
    else if (dif.rearm) done_ff <= 1'b0;
  end

  // [R23] offset window
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ofs_q_ff   <= 1'b0;
      ofs_acc_ff <= 1'b0;
      ofs_res_ff <= 1'b0;
    end else begin
      ofs_q_ff <= dif.ofs_en;
      if (!dif.ofs_en) ofs_acc_ff <= 1'b0;
      else if (!ofs_q_ff || dif.rearm) ofs_acc_ff <= s2_ff[`AMP_F_OFS];
      else if (scp) ofs_acc_ff <= 1'b0;
      else ofs_acc_ff <= ofs_acc_ff & s2_ff[`AMP_F_OFS];
      if (dif.snap) ofs_res_ff <= ofs_acc_ff & dif.ofs_en;
    end
  end

  // [R15] open load or offset
  assign bit2 = dif.ofs_en ? ofs_res_ff : res_ff.open;
  // [R14] channel byte layout
  assign dif.res[IDX]     = {type_ff, res_ff.load, bit2, res_ff.vs, res_ff.gnd};
  assign dif.busy[IDX]    = (st_ff != CY_IDLE);
  assign dif.done[IDX]    = done_ff;
  assign dif.ton_run[IDX] = (st_ff == CY_TON);

endmodule : amp_chan_diag

// File: hdl/amp_ctrl_top.sv
`timescale 1ns/10ps
`include "amp_defines.svh"
module amp_ctrl_top import amp_pkg::*; #(
  parameter int unsigned ACQ_CYC   =
    `AMP_ACQ_MS * `AMP_CLK_MHZ * `AMP_KHZ_PER_MHZ,
  parameter int unsigned RECHK_CYC =
    `AMP_RECHK_MS * `AMP_CLK_MHZ * `AMP_KHZ_PER_MHZ
) (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       scl_clk,
  input  wire logic       sda_in,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic       thermal_warn,
  input  wire logic [3:0] flt_gnd_src,
  input  wire logic [3:0] flt_gnd_sink,
  input  wire logic [3:0] flt_short_vs,
  input  wire logic [3:0] flt_short_load,
  input  wire logic [3:0] flt_open_load,
  input  wire logic [3:0] flt_offset,
  input  wire logic [3:0] flt_scp,
  output logic            diag_enable,
  output logic            offset_enable,
  output logic            gain_front_low,
  output logic            gain_rear_low,
  output logic            unmute_front,
  output logic            unmute_rear,
  output logic            amp_run,
  output logic            line_drv_mode,
  output logic [3:0]      ton_pulse_run,
  output logic [3:0]      diag_busy
);

  amp_diag_if dif ();

  logic         smp_bit;
  logic         smp_tgl;
  logic         scl_s1_ff;
  logic         scl_s2_ff;
  logic         scl_s3_ff;
  logic         sda_s1_ff;
  logic         sda_s2_ff;
  logic         sda_s3_ff;
  logic         tgl_s1_ff;
  logic         tgl_s2_ff;
  logic         tgl_s3_ff;
  logic         thw_s1_ff;
  logic         thw_s2_ff;
  amp_link_st_t st_ff;
  logic [3:0]   cnt_ff;
  logic [7:0]   sh_ff;
  logic         rw_ff;
  logic [1:0]   idx_ff;
  logic         low_ff;
  logic [7:0]   tx_ff;
  logic [7:0]   pend_a_ff;
  logic [7:0]   ctrl_a_ff;
  logic [7:0]   ctrl_b_ff;
  logic [7:0]   snap_ff [4];
  logic         snap_dly_ff;
  logic         rearm_ff;
  logic         ton_start_ff;
  logic         start_evt;
  logic         stop_evt;
  logic         scl_fall;
  logic         bit_evt;
  logic         addr_hit;
  logic         wr_byte_evt;
  logic         rd_done_evt;
  logic         snap_evt;
  logic [7:0]   rx_byte;
  logic [7:0]   live [4];

  //////////////////////////////////////////////////////////////////////////
  amp_link_sampler u_sampler (
    .scl_clk (scl_clk),
    .rst_n   (rst_n),
    .sda_in  (sda_in),
    .bit_ff  (smp_bit),
    .tgl_ff  (smp_tgl)
  );

  for (genvar i = 0; i < 4; i++) begin : g_chan
    amp_chan_diag #(
      .IDX       (i),
      .ACQ_CYC   (ACQ_CYC),
      .RECHK_CYC (RECHK_CYC)
    ) u_chan (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .flt_pins ({flt_scp[i], flt_offset[i], flt_open_load[i],
                  flt_short_load[i], flt_short_vs[i], flt_gnd_sink[i],
                  flt_gnd_src[i]}),
      .dif      (dif)
    );
  end

  //////////////////////////////////////////////////////////////////////////
  // Pin and toggle synchronisers; edge logic reads only the later stages.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s1_ff <= 1'b1;
      scl_s2_ff <= 1'b1;
      scl_s3_ff <= 1'b1;
      sda_s1_ff <= 1'b1;
      sda_s2_ff <= 1'b1;
      sda_s3_ff <= 1'b1;
    end else begin
      scl_s1_ff <= scl_clk;
      scl_s2_ff <= scl_s1_ff;
      scl_s3_ff <= scl_s2_ff;
      sda_s1_ff <= sda_in;
      sda_s2_ff <= sda_s1_ff;
      sda_s3_ff <= sda_s2_ff;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tgl_s1_ff <= 1'b0;
      tgl_s2_ff <= 1'b0;
      tgl_s3_ff <= 1'b0;
      thw_s1_ff <= 1'b0;
      thw_s2_ff <= 1'b0;
    end else begin
      tgl_s1_ff <= smp_tgl;
      tgl_s2_ff <= tgl_s1_ff;
      tgl_s3_ff <= tgl_s2_ff;
      thw_s1_ff <= thermal_warn;
      thw_s2_ff <= thw_s1_ff;
    end
  end

  assign start_evt = scl_s2_ff && scl_s3_ff && sda_s3_ff && !sda_s2_ff;
  assign stop_evt  = scl_s2_ff && scl_s3_ff && !sda_s3_ff && sda_s2_ff;
  assign scl_fall  = scl_s3_ff && !scl_s2_ff;
  assign bit_evt   = tgl_s2_ff ^ tgl_s3_ff;
  assign rx_byte   = {sh_ff[6:0], smp_bit};
  // [R1] fixed slave address
  assign addr_hit  = (sh_ff[6:0] == `AMP_SLAVE_ADDR);

  assign wr_byte_evt = (st_ff == LK_WRB) && bit_evt
                       && cnt_ff == `AMP_BIT_LAST && idx_ff <= `AMP_IDX_B;
  assign snap_evt    = (st_ff == LK_ADDR) && bit_evt
                       && cnt_ff == `AMP_BIT_LAST && addr_hit && smp_bit;
  assign rd_done_evt = (st_ff == LK_RACK) && bit_evt
                       && (smp_bit || idx_ff == `AMP_IDX_RD_LAST);

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff  <= LK_IDLE;
      cnt_ff <= '0;
      sh_ff  <= '0;
      rw_ff  <= 1'b0;
      idx_ff <= '0;
      low_ff <= 1'b0;
      tx_ff  <= '0;
    end else if (stop_evt) begin
      st_ff  <= LK_IDLE;
      low_ff <= 1'b0;
    end else if (start_evt) begin
      st_ff  <= LK_ADDR;
      cnt_ff <= '0;
      low_ff <= 1'b0;
    end else begin
      unique case (st_ff)
        LK_IDLE: begin
          low_ff <= 1'b0;
        end
        LK_ADDR: begin
          if (bit_evt) begin
            sh_ff <= rx_byte;
            if (cnt_ff == `AMP_BIT_LAST) begin
              cnt_ff <= '0;
              rw_ff  <= smp_bit;
              st_ff  <= addr_hit ? LK_AACK : LK_IDLE;
            end else begin
              cnt_ff <= cnt_ff + 1'b1;
            end
          end
        end
        LK_AACK: begin
          if (scl_fall) begin
            if (!low_ff) begin
              low_ff <= 1'b1;
            end else begin
              idx_ff <= '0;
              cnt_ff <= '0;
              if (rw_ff) begin
                // [R3] first byte out
                st_ff  <= LK_RDB;
                tx_ff  <= snap_ff[0];
                low_ff <= ~snap_ff[0][7];
              end else begin
                st_ff  <= LK_WRB;
                low_ff <= 1'b0;
              end
            end
          end
        end
        LK_WRB: begin
          if (bit_evt) begin
            sh_ff <= rx_byte;
            if (cnt_ff == `AMP_BIT_LAST) begin
              cnt_ff <= '0;
              // [R2] extra bytes not acknowledged
              st_ff  <= (idx_ff <= `AMP_IDX_B) ? LK_WACK : LK_IDLE;
            end else begin
              cnt_ff <= cnt_ff + 1'b1;
            end
          end
        end
        LK_WACK: begin
          if (scl_fall) begin
            if (!low_ff) begin
              low_ff <= 1'b1;
            end else begin
              low_ff <= 1'b0;
              idx_ff <= idx_ff + 1'b1;
              st_ff  <= LK_WRB;
            end
          end
        end
        LK_RDB: begin
          if (bit_evt) begin
            tx_ff  <= {tx_ff[6:0], 1'b0};
            cnt_ff <= cnt_ff + 1'b1;
          end
          if (scl_fall) begin
            if (cnt_ff == `AMP_BIT_DONE) begin
              low_ff <= 1'b0;
              st_ff  <= LK_RACK;
            end else begin
              low_ff <= ~tx_ff[7];
            end
          end
        end
        LK_RACK: begin
          if (bit_evt) begin
            cnt_ff <= '0;
            // [R3] next byte in order
            if (!smp_bit && idx_ff != `AMP_IDX_RD_LAST) begin
              idx_ff <= idx_ff + 1'b1;
              tx_ff  <= snap_ff[idx_ff + 2'h1];
              st_ff  <= LK_RDB;
            end else begin
              st_ff <= LK_IDLE;
            end
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Control bytes take effect together once byte B arrives.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pend_a_ff <= `AMP_CTRL_RST;
      ctrl_a_ff <= `AMP_CTRL_RST;
      ctrl_b_ff <= `AMP_CTRL_RST;
    end else if (wr_byte_evt) begin
      // [R25] don't-care bits dropped
      if (idx_ff != `AMP_IDX_B) begin
        pend_a_ff <= rx_byte & `AMP_A_MASK;
      end else begin
        ctrl_a_ff <= pend_a_ff;
        ctrl_b_ff <= rx_byte & `AMP_B_MASK;
      end
    end
  end

  // Turn-on cycles start if the stage is in standby before or after byte B, or on a read in standby.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ton_start_ff <= 1'b0;
      rearm_ff     <= 1'b0;
      snap_dly_ff  <= 1'b0;
    end else begin
      ton_start_ff <= (wr_byte_evt && idx_ff == `AMP_IDX_B
                       && pend_a_ff[`AMP_A_DIAG_EN]
                       && (!ctrl_b_ff[`AMP_B_STBY] || !rx_byte[`AMP_B_STBY]))
                      || (rd_done_evt && ctrl_a_ff[`AMP_A_DIAG_EN]
                          && !ctrl_b_ff[`AMP_B_STBY]);
      // [R16] re-arm after read
      rearm_ff     <= rd_done_evt;
      snap_dly_ff  <= snap_evt;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  always_comb begin
    // [R10] thermal warning
    // [R11] cycle terminated
    live[0] = {thw_s2_ff, (|dif.done) && !(|dif.busy), 1'b0, dif.res[0]};
    // [R12] offset detection active
    live[1] = {ctrl_a_ff[`AMP_A_OFS_EN], 2'b00, dif.res[1]};
    // [R13] standby and diag mirror
    live[2] = {ctrl_b_ff[`AMP_B_STBY], ctrl_a_ff[`AMP_A_DIAG_EN], 1'b0,
               dif.res[2]};
    // [R25] unused bits zero
    live[3] = {3'b000, dif.res[3]};
  end

  // [R16] read sees stored results
  // [R18] one fault per cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) snap_ff[i] <= '0;
    end else if (snap_dly_ff) begin
      for (int i = 0; i < 4; i++) snap_ff[i] <= live[i];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // [R4] diagnostic enable
  assign dif.diag_en   = ctrl_a_ff[`AMP_A_DIAG_EN];
  // [R5] offset detection enable
  assign dif.ofs_en    = ctrl_a_ff[`AMP_A_OFS_EN];
  assign dif.amp_on    = ctrl_b_ff[`AMP_B_STBY];
  assign dif.ton_start = ton_start_ff;
  assign dif.rearm     = rearm_ff;
  assign dif.snap      = snap_evt;

  assign diag_enable    = ctrl_a_ff[`AMP_A_DIAG_EN];
  assign offset_enable  = ctrl_a_ff[`AMP_A_OFS_EN];
  // [R6] gain select
  assign gain_front_low = ctrl_a_ff[`AMP_A_GAIN_F];
  assign gain_rear_low  = ctrl_a_ff[`AMP_A_GAIN_R];
  // [R7] mute control
  assign unmute_front   = ctrl_a_ff[`AMP_A_UNMUTE_F];
  assign unmute_rear    = ctrl_a_ff[`AMP_A_UNMUTE_R];
  // [R8] standby control
  assign amp_run        = ctrl_b_ff[`AMP_B_STBY];
  // [R9] threshold mode
  assign line_drv_mode  = ctrl_b_ff[`AMP_B_LINE];
  assign ton_pulse_run  = dif.ton_run;
  assign diag_busy      = dif.busy;
  assign sda_o          = 1'b0;
  assign sda_oe         = low_ff;

endmodule : amp_ctrl_top

// File: hdl/amp_defines.svh
//
// Behaviour
// [R1] Answer seven-bit address 1101100; bit zero selects direction.
// [R2] Master writes control byte A then B.
// [R3] Read returns four channel diagnostic bytes in order.
// [R4] Control A bit 6 enables diagnostics.
// [R5] Control A bit 5 enables offset detection.
// [R6] Control A bits 4/3 select 12 dB gain.
// [R7] Control A bits 2/1 unmute front/rear channels.
// [R8] Control B bit 4 releases standby.
// [R9] Control B bit 3 selects line-driver thresholds.
// [R10] First byte bit 7 shows thermal warning.
// [R11] First byte bit 6 shows cycle terminated.
// [R12] Second byte bit 7 shows offset detection active.
// [R13] Third byte bits 7/6 mirror standby, diagnostics.
// [R14] Channel bits show type, short load, supply, ground.
// [R15] Bit 2 is open load or excess offset.
// [R16] Read re-arms cycles; returns previous results.
// [R17] Fault reported only if present whole period.
// [R18] Coexisting faults reported one per read cycle.
// [R19] Double faults resolved by fixed priority.
// [R20] Permanent diagnostics never flag open load.
// [R21] Host ends offset test with a read.
// [R22] Host waits 500 ms / 20 ms around mute.
// [R23] Offset window runs from previous read to read.
// [R24] Overload rechecked after 1 ms, then 100 ms cycle.
// [R25] Don't-care bits ignored, unused bits read zero.
`ifndef AMP_DEFINES_SVH
`define AMP_DEFINES_SVH

`define AMP_SLAVE_ADDR  7'h6c
`define AMP_BIT_LAST    4'h7
`define AMP_BIT_DONE    4'h8
`define AMP_IDX_B       2'h1
`define AMP_IDX_RD_LAST 2'h3
`define AMP_CTRL_RST    8'h00
`define AMP_A_MASK      8'h7e
`define AMP_B_MASK      8'h18

`define AMP_A_DIAG_EN   6
`define AMP_A_OFS_EN    5
`define AMP_A_GAIN_F    4
`define AMP_A_GAIN_R    3
`define AMP_A_UNMUTE_F  2
`define AMP_A_UNMUTE_R  1
`define AMP_B_STBY      4
`define AMP_B_LINE      3

`define AMP_F_GND_SO    0
`define AMP_F_GND_SK    1
`define AMP_F_VS        2
`define AMP_F_LOAD      3
`define AMP_F_OPEN      4
`define AMP_F_OFS       5
`define AMP_F_SCP       6
`define AMP_F_W         7

`define AMP_CLK_MHZ     200
`define AMP_KHZ_PER_MHZ 1000
`define AMP_ACQ_MS      100
`define AMP_RECHK_MS    1
`define AMP_CNT_W       25

`endif

// File: hdl/amp_diag_if.sv
`timescale 1ns/10ps
interface amp_diag_if;
  import amp_pkg::*;
  logic       diag_en;
  logic       ofs_en;
  logic       amp_on;
  logic       ton_start;
  logic       rearm;
  logic       snap;
  logic [3:0] busy;
  logic [3:0] done;
  logic [3:0] ton_run;
  amp_res_t   res [4];

  modport ctl (output diag_en, ofs_en, amp_on, ton_start, rearm, snap,
               input  busy, done, ton_run, res);
  modport chan (input  diag_en, ofs_en, amp_on, ton_start, rearm, snap,
                output busy, done, ton_run, res);
endinterface : amp_diag_if

// File: hdl/amp_link_sampler.sv
`timescale 1ns/10ps
module amp_link_sampler (
  input  wire logic scl_clk,
  input  wire logic rst_n,
  input  wire logic sda_in,
  output logic      bit_ff,
  output logic      tgl_ff
);

  // Each rising bus clock takes one data bit and flips the toggle, which
  // the system-clock side turns into a one-cycle bit event.
  always_ff @(posedge scl_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_ff <= 1'b0;
      tgl_ff <= 1'b0;
    end else begin
      bit_ff <= sda_in;
      tgl_ff <= ~tgl_ff;
    end
  end

endmodule : amp_link_sampler

// File: hdl/amp_pkg.sv
package amp_pkg;

  typedef enum logic [6:0] {
    LK_IDLE = 7'h01,
    LK_ADDR = 7'h02,
    LK_AACK = 7'h04,
    LK_WRB  = 7'h08,
    LK_WACK = 7'h10,
    LK_RDB  = 7'h20,
    LK_RACK = 7'h40
  } amp_link_st_t;

  typedef enum logic [3:0] {
    CY_IDLE  = 4'h1,
    CY_RECHK = 4'h2,
    CY_PERM  = 4'h4,
    CY_TON   = 4'h8
  } amp_cyc_st_t;

  typedef struct packed {
    logic load;
    logic open;
    logic vs;
    logic gnd;
  } amp_flt_t;

  typedef logic [4:0] amp_res_t;

  // Resolves coexisting faults to the one reported first, but a supply short keeps a source-ground short and turn-on sink-ground plus open reports open.
  function automatic amp_flt_t amp_prio(input logic ton,
                                        input logic gnd_so,
                                        input logic gnd_sk,
                                        input logic vs,
                                        input logic load,
                                        input logic open);
    amp_flt_t r;
    r = '0;
    if (vs) begin
      r.vs  = 1'b1;
      r.gnd = gnd_so;
    end else if (gnd_so || gnd_sk) begin
      if (gnd_sk && !gnd_so && open && ton) r.open = 1'b1;
      else r.gnd = 1'b1;
    end else if (load) begin
      r.load = 1'b1;
    end else if (open && ton) begin
      r.open = 1'b1;
    end
    return r;
  endfunction : amp_prio

endpackage : amp_pkg

// File: testbench/amp_ctrl_checker.sv
`timescale 1ns/10ps
module amp_ctrl_checker #(
  parameter int unsigned ACQ_CYC   = 50,
  parameter int unsigned RECHK_CYC = 10
) (
  input wire logic       mclk,
  input wire logic       rst_n,
  input wire logic       scl_clk,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  input wire logic       diag_enable,
  input wire logic       offset_enable,
  input wire logic       gain_front_low,
  input wire logic       gain_rear_low,
  input wire logic       unmute_front,
  input wire logic       unmute_rear,
  input wire logic       amp_run,
  input wire logic       line_drv_mode,
  input wire logic [3:0] ton_pulse_run,
  input wire logic [3:0] diag_busy
);
  localparam int BUSY_MAX = ACQ_CYC + RECHK_CYC + 40;
  wire [7:0] ctl = {diag_enable, offset_enable, gain_front_low,
    gain_rear_low, unmute_front, unmute_rear, amp_run, line_drv_mode};
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  a_sda_low_only: assert property (sda_o == 1'b0)
    else $error("data pin driven high");
  a_oe_min_hold: assert property ($rose(sda_oe) |-> sda_oe [*8])
    else $error("bus drive too short");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_clk)
    else $error("data changed while clock high");
  a_ctl_at_ack: assert property ($changed(ctl) |-> ##[1:40] sda_oe)
    else $error("controls changed outside a write");
  a_busy_min: assert property ($rose(diag_busy[2]) |-> diag_busy[2] [*8])
    else $error("cycle ended too early");
  a_busy_max: assert property
    ($rose(diag_busy[2]) |-> ##[1:BUSY_MAX] !diag_busy[2])
    else $error("cycle ran too long");
  a_busy_needs_diag: assert property ($rose(diag_busy[0]) |-> diag_enable)
    else $error("cycle without diagnostics enabled");
  a_perm_needs_run: assert property
    ($rose(diag_busy[2]) && !ton_pulse_run[2] |-> amp_run)
    else $error("permanent cycle in standby");
endmodule : amp_ctrl_checker

bind amp_ctrl_top amp_ctrl_checker #(
  .ACQ_CYC(ACQ_CYC), .RECHK_CYC(RECHK_CYC)) u_chk (
  .mclk(mclk), .rst_n(rst_n), .scl_clk(scl_clk), .sda_o(sda_o),
  .sda_oe(sda_oe), .diag_enable(diag_enable), .offset_enable(offset_enable),
  .gain_front_low(gain_front_low), .gain_rear_low(gain_rear_low),
  .unmute_front(unmute_front), .unmute_rear(unmute_rear),
  .amp_run(amp_run), .line_drv_mode(line_drv_mode),
  .ton_pulse_run(ton_pulse_run), .diag_busy(diag_busy));

// File: testbench/amp_host_model.sv
`timescale 1ns/10ps
module amp_host_model (
  output logic     scl,
  output wire      sda,
  input wire logic sda_o,
  input wire logic sda_oe
);
  logic m_low = 1'b0;
  initial scl = 1'b1;
  assign sda = !(m_low || (sda_oe && !sda_o));

  task automatic bitx(input logic v, output logic r);
    #40 m_low = !v;
    #40 scl = 1'b1;
    #40 r = sda;
    #40 scl = 1'b0;
  endtask : bitx

  task automatic xbyte(input logic [7:0] w, input logic ai,
                       output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bitx(w[i], r[i]);
    bitx(ai, a);
    ack = !a;
  endtask : xbyte

  task automatic frame(input logic s);
    #81.3 m_low = !s;
    #80 scl = 1'b1;
    #80 m_low = s;
    if (s) #80 scl = 1'b0;
  endtask : frame

  task automatic wr(input logic [7:0] adr, a, b, output logic [2:0] ack);
    logic [7:0] r;
    frame(1'b1);
    xbyte(adr, 1'b1, r, ack[2]);
    xbyte(a, 1'b1, r, ack[1]);
    xbyte(b, 1'b1, r, ack[0]);
    frame(1'b0);
  endtask : wr

  task automatic rd(output logic [31:0] d);
    logic [7:0] r;
    logic       ak;
    frame(1'b1);
    xbyte(8'hd9, 1'b1, r, ak);
    for (int k = 3; k >= 0; k--) xbyte(8'hff, k == 0, d[k*8 +: 8], ak);
    frame(1'b0);
  endtask : rd
endmodule : amp_host_model

// File: testbench/tb_amp_i2c_control_diag_readout.sv
`timescale 1ns/10ps
`define CHK(g, e) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("unexpected at %0t: got %h want %h", $time, g, e); \
  end \
end
module tb_amp_i2c_control_diag_readout;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic       thermal_warn = 1'b0;
  logic [3:0] f_gs = 4'h0, f_gk = 4'h0, f_vs = 4'h0, f_ld = 4'h0;
  logic [3:0] f_op = 4'h0, f_of = 4'h0, f_sc = 4'h0;
  wire        scl, sda, sda_o, sda_oe;
  wire  [3:0] busy;
  wire  [7:0] ctl;
  int         failures = 0;
  int         samples_checked = 0;

  initial forever #2.5 mclk = ~mclk;

  amp_host_model hm (.scl(scl), .sda(sda), .sda_o(sda_o), .sda_oe(sda_oe));
  amp_ctrl_top #(.ACQ_CYC(50), .RECHK_CYC(10)) DUT (
    .mclk(mclk), .rst_n(rst_n), .scl_clk(scl), .sda_in(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .thermal_warn(thermal_warn),
    .flt_gnd_src(f_gs), .flt_gnd_sink(f_gk), .flt_short_vs(f_vs),
    .flt_short_load(f_ld), .flt_open_load(f_op), .flt_offset(f_of),
    .flt_scp(f_sc), .diag_enable(ctl[7]), .offset_enable(ctl[6]),
    .gain_front_low(ctl[5]), .gain_rear_low(ctl[4]),
    .unmute_front(ctl[3]), .unmute_rear(ctl[2]), .amp_run(ctl[1]),
    .line_drv_mode(ctl[0]), .ton_pulse_run(), .diag_busy(busy));

  ////////////////////////////////////////////////////////////////////////
  task automatic do_reset;
    @(posedge mclk);
    rst_n <= 1'b0;
    {thermal_warn, f_gs, f_gk, f_vs, f_ld, f_op, f_of, f_sc} <= '0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask : do_reset

  task automatic wr(input logic [7:0] a, b);
    logic [2:0] ack;
    hm.wr(8'hd8, a, b, ack);
    `CHK(ack, 3'b111)
  endtask : wr

  task automatic rd_chk(input logic [31:0] e);
    logic [31:0] d;
    hm.rd(d);
    `CHK(d, e)
  endtask : rd_chk

  task automatic wait_busy(input logic want);
    for (int n = 0; (busy != 4'h0) !== want; n++) begin
      if (n == 2000) begin
        failures++;
        conclude();
      end
      @(posedge mclk);
    end
  endtask : wait_busy

  task automatic s_controls;
    logic [2:0] ack;
    do_reset();
    `CHK(ctl, 8'h00)
    hm.wr(8'hda, 8'h7e, 8'h18, ack);
    `CHK(ack, 3'b000)
    `CHK(ctl, 8'h00)
    wr(8'hd5, 8'hea);
    `CHK(ctl, 8'ha9)
    repeat (250) @(posedge mclk);
    wr(8'h2a, 8'h15);
    `CHK(ctl, 8'h56)
  endtask : s_controls

  task automatic s_layout;
    do_reset();
    thermal_warn <= 1'b1;
    f_of <= 4'h1;
    wr(8'h20, 8'h10);
    rd_chk(32'h84808000);
    @(posedge mclk);
    thermal_warn <= 1'b0;
    f_of <= 4'h0;
    wr(8'h40, 8'h10);
    rd_chk(32'h0000c000);
  endtask : s_layout

  task automatic s_turn_on;
    do_reset();
    f_gs <= 4'h5;
    f_gk <= 4'h8;
    f_vs <= 4'h1;
    f_op <= 4'ha;
    wr(8'h40, 8'h00);
    wait_busy(1'b0);
    {f_gs, f_gk, f_vs, f_op} <= '0;
    rd_chk(32'h43044104);
    wait_busy(1'b0);
    rd_chk(32'h40004000);
  endtask : s_turn_on

  task automatic s_perm;
    do_reset();
    wr(8'h40, 8'h10);
    wait_busy(1'b0);
    rd_chk(32'h4000c000);
    @(posedge mclk);
    f_sc <= 4'hc;
    f_ld <= 4'h4;
    f_op <= 4'h8;
    wait_busy(1'b1);
    wait_busy(1'b0);
    {f_sc, f_ld, f_op} <= '0;
    rd_chk(32'h4000d810);
  endtask : s_perm

  task automatic conclude;
    $display("failures=%0d samples_checked=%0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude

  initial begin
    s_controls();
    s_layout();
    s_turn_on();
    s_perm();
    conclude();
  end
endmodule : tb_amp_i2c_control_diag_readout
